// ---- fcg_pkg.sv ----
// Constants, mode codes and field decoders shared by the clock generator files
package fcg_pkg;
  // Register indices on the byte-wide register port
  localparam logic [2:0] CTL1_ADDR = 3'h0;
  localparam logic [2:0] CTL2_ADDR = 3'h1;
  localparam logic [2:0] STAT1_ADDR = 3'h2;
  localparam logic [2:0] STAT2_ADDR = 3'h3;
  localparam logic [2:0] FILT_HI_ADDR = 3'h4;
  localparam logic [2:0] FILT_LO_ADDR = 3'h5;
  localparam logic [2:0] TRIM_ADDR = 3'h6;
  // First control register fields; bit 0 is not stored
  localparam int HIGH_GAIN_BIT = 7;
  localparam int RANGE_BIT = 6;
  localparam int REF_SELECT_BIT = 5;
  localparam int MODE_REQ_LSB = 3;
  localparam int OSC_KEEP_BIT = 2;
  localparam int LOC_DISABLE_BIT = 1;
  localparam logic [7:0] CTL1_WMASK = 8'hfe;
  // Second control register fields
  localparam int LOCK_RST_BIT = 7;
  localparam int MULT_LSB = 4;
  localparam int CLK_RST_BIT = 3;
  localparam int DIV_LSB = 0;
  // Status register fields
  localparam int MODE_ACT_LSB = 6;
  localparam int EXT_VALID_BIT = 5;
  localparam int CLK_LOST_BIT = 4;
  localparam int LOCKED_BIT = 3;
  localparam int LOCK_LOST_BIT = 2;
  localparam int IRQ_BIT = 0;
  localparam int DCO_STABLE_BIT = 0;
  // Reset values
  localparam logic [7:0] CTL1_RESET = 8'h00;
  localparam logic [7:0] CTL2_RESET = 8'h00;
  localparam logic [11:0] FILTER_RESET = 12'h800;
  localparam logic [7:0] TRIM_RESET = 8'h80;
  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int MODE_SETTLE_NS = 32;
  localparam int MODE_SETTLE_CYC = (MODE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOSS_TIMEOUT_NS = 100000;
  localparam int LOSS_TIMEOUT_CYC = (LOSS_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Loop arithmetic
  localparam logic [4:0] MULT_BASE = 5'h04;
  localparam logic [2:0] INT_REF_DIV = 3'h7;
  localparam logic [2:0] EXT_REF_DIV = 3'h1;
  localparam int LOCK_TOL = 2;

  typedef enum logic [1:0] {
    MODE_SELF = 2'b00,
    MODE_ENG_INT = 2'b01,
    MODE_BYP_EXT = 2'b10,
    MODE_ENG_EXT = 2'b11
  } fcg_mode_t;

  // Multiplier N: 4 plus twice the code
  function automatic logic [4:0] mult_of(input logic [2:0] code);
    return MULT_BASE + {1'b0, code, 1'b0};
  endfunction

  // Output divisor R: power of two
  function automatic logic [7:0] div_of(input logic [2:0] code);
    return 8'h01 << code;
  endfunction

  // DCO ticks expected per reference window: P times N, P is 64 or 1
  function automatic logic [11:0] loop_target(input logic [4:0] mult, input logic pre_one);
    return pre_one ? {7'h00, mult} : {1'b0, mult, 6'h00};
  endfunction
endpackage

// ---- fcg_out_divider.sv ----
// Output divider: one output tick for every R source ticks
`timescale 1ns/10ps
module fcg_out_divider #(
  parameter int DW = 8
) (
  input logic mclk,
  input logic resetn,
  input logic src_tick,
  input logic [DW-1:0] divisor,
  output logic out_tick
);
  logic [DW-1:0] cnt_q;
  logic last;

  // Compare with >= so a smaller divisor written mid-count cannot stall it
  assign last = (cnt_q >= divisor - DW'(1));

  // Count source ticks and emit on the last of each group
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      cnt_q <= '0;
      out_tick <= 1'b0;
    end
    else
    begin
      out_tick <= src_tick && last;
      if (src_tick)
        cnt_q <= last ? '0 : cnt_q + DW'(1);
    end
  end
endmodule

// ---- fcg_freq_loop.sv ----
// Frequency comparator of the loop: DCO ticks counted per reference window
`timescale 1ns/10ps
module fcg_freq_loop #(
  parameter int CW = 12
) (
  input logic mclk,
  input logic resetn,
  input logic ref_tick,
  input logic [2:0] ref_div,
  input logic dco_tick,
  input logic [CW-1:0] target,
  input logic engaged,
  output logic adj_up,
  output logic adj_down,
  output logic locked,
  output logic stable
);
  logic [2:0] ref_cnt_q;
  logic [CW-1:0] dco_cnt_q;
  logic win_end;
  logic slow;
  logic fast;

  // A window closes on the reference tick that completes the divide count
  assign win_end = ref_tick && (ref_cnt_q == ref_div - 3'h1);
  assign slow = ({1'b0, dco_cnt_q} + (CW+1)'(fcg_pkg::LOCK_TOL)) < {1'b0, target};
  assign fast = {1'b0, dco_cnt_q} > ({1'b0, target} + (CW+1)'(fcg_pkg::LOCK_TOL));

  // Reference divider
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      ref_cnt_q <= 3'h0;
    else if (win_end)
      ref_cnt_q <= 3'h0;
    else if (ref_tick)
      ref_cnt_q <= ref_cnt_q + 3'h1;
  end

  // Saturating count, so a runaway DCO reads as fast rather than wrapping
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      dco_cnt_q <= '0;
    else if (win_end)
      dco_cnt_q <= {{(CW-1){1'b0}}, dco_tick};
    else if (dco_tick && !(&dco_cnt_q))
      dco_cnt_q <= dco_cnt_q + CW'(1);
  end

  // Filter steps only while the loop is closed
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      adj_up <= 1'b0;
      adj_down <= 1'b0;
    end
    else
    begin
      adj_up <= win_end && engaged && slow;
      adj_down <= win_end && engaged && fast;
    end
  end

  // Lock is judged even open loop; stable needs two good windows in a row
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      locked <= 1'b0;
      stable <= 1'b0;
    end
    else if (win_end)
    begin
      locked <= !slow && !fast;
      stable <= !slow && !fast && locked;
    end
  end
endmodule

// ---- fcg_clock_config.sv ----
// Clock generator configuration: registers, mode control, monitors, output clock
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/10ps
// Notes on behaviour
// - Multiply code 000 gives N=4, each step adds 2, up to 18.
// - Reduce code gives divisor R as two to the power of the code.
// - Bypassed modes output DCO or external reference divided by R.
// - Internal engaged mode locks to internal reference /7 times 64, N, over R.
// - External engaged mode uses prescale 64 or 1 by range, times N, over R.
// - Reset leaves the block in self-clocked mode.
// - First control register layout; bit 0 always reads zero.
// - Request code 11 selects external engaged mode.
// - High gain clear selects low-power oscillator; ref select requests oscillator only in an external mode, actual or requested.
// - Second control register layout: reset enables, multiply and reduce codes.
// - Lock loss raises interrupt unless its reset enable is set.
// - Clock loss raises interrupt unless reset enabled; detection disable bit.
// - First status register read-only; a write clears the interrupt flag.
// - Filter value is 12 bits; user writes count only in self-clocked mode.
// - DCO enable follows the actual mode; oscillator enable also follows the request.
// - Request code 01 selects internal engaged mode.
// - Actual mode follows a request only after several cycles.
module fcg_clock_config #(
  parameter int LOSS_TIMEOUT_CYC = fcg_pkg::LOSS_TIMEOUT_CYC
) (
  input logic mclk,
  input logic resetn,
  input logic [2:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  output logic [7:0] reg_rdata,
  input logic irg_tick,
  input logic ext_ref_tick,
  input logic dco_tick,
  output logic clkgen_output,
  output logic [11:0] loop_filter_value,
  output logic [7:0] osc_trim,
  output logic irg_enable,
  output logic dco_enable,
  output logic osc_enable,
  output logic high_gain_enable,
  output logic [1:0] clock_mode_actual,
  output logic irq_request,
  output logic lock_loss_reset,
  output logic clock_loss_reset
);
  localparam logic [3:0] SETTLE_LAST = 4'(fcg_pkg::MODE_SETTLE_CYC - 1);
  localparam logic [15:0] WD_LAST = 16'(LOSS_TIMEOUT_CYC - 1);

  logic [7:0] ctl1_q;
  logic [7:0] ctl2_q;
  logic [7:0] trim_q;
  logic [11:0] filter_q;
  logic [3:0] settle_q;
  logic [15:0] wd_q;
  logic ext_valid_q;
  logic locked_prev_q;
  logic lock_lost_q;
  logic clk_lost_q;
  logic irq_q;
  logic lock_rst_q;
  logic clk_rst_q;
  logic irg_en_q;
  logic dco_en_q;
  logic osc_en_q;
  logic hgo_en_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  fcg_pkg::fcg_mode_t mode_q;
  fcg_pkg::fcg_mode_t req;
  logic ref_ok;
  logic ctl1_wr;
  logic stat_wr;
  logic engaged;
  logic ext_loop;
  logic pre_one;
  logic [4:0] mult_n;
  logic [7:0] div_val;
  logic [11:0] loop_tgt;
  logic src_tick;
  logic adj_up;
  logic adj_down;
  logic loop_locked;
  logic dco_stable;
  logic wd_timeout;
  logic lock_evt;
  logic clk_evt;
  logic lock_loss_reset_enable;
  logic clock_loss_reset_enable;

  assign ctl1_wr = reg_wr && (reg_addr == fcg_pkg::CTL1_ADDR);
  assign stat_wr = reg_wr && (reg_addr == fcg_pkg::STAT1_ADDR);
  assign req = fcg_pkg::fcg_mode_t'(ctl1_q[fcg_pkg::MODE_REQ_LSB +: 2]);
  assign lock_loss_reset_enable = ctl2_q[fcg_pkg::LOCK_RST_BIT];
  assign clock_loss_reset_enable = ctl2_q[fcg_pkg::CLK_RST_BIT];
  assign mult_n = fcg_pkg::mult_of(ctl2_q[fcg_pkg::MULT_LSB +: 3]);
  assign div_val = fcg_pkg::div_of(ctl2_q[fcg_pkg::DIV_LSB +: 3]);
  // Engaged modes have the low mode bit set; external modes the high bit
  assign engaged = mode_q[0];
  assign ext_loop = mode_q[1];
  // range bit chooses a prescale of 1 in external engaged mode
  assign pre_one = ext_loop && ctl1_q[fcg_pkg::RANGE_BIT];
  // DCO ticks expected per reference window
  assign loop_tgt = fcg_pkg::loop_target(mult_n, pre_one);
  // bypassed external passes the reference itself to the divider
  assign src_tick = (mode_q == fcg_pkg::MODE_BYP_EXT) ? ext_ref_tick : dco_tick;
  assign wd_timeout = (wd_q == WD_LAST);
  // loss of clock counts only with detection enabled and an external mode
  assign clk_evt = ext_valid_q && wd_timeout && ext_loop
                   && !ctl1_q[fcg_pkg::LOC_DISABLE_BIT];
  // lock loss is a drop of lock while the loop is closed
  assign lock_evt = engaged && locked_prev_q && !loop_locked;

  // Loop comparator; internal reference is divided by 7, external is not
  fcg_freq_loop #(
    .CW(12)
  ) u_loop (
    .mclk(mclk),
    .resetn(resetn),
    .ref_tick(ext_loop ? ext_ref_tick : irg_tick),
    .ref_div(ext_loop ? fcg_pkg::EXT_REF_DIV : fcg_pkg::INT_REF_DIV),
    .dco_tick(dco_tick),
    .target(loop_tgt),
    .engaged(engaged),
    .adj_up(adj_up),
    .adj_down(adj_down),
    .locked(loop_locked),
    .stable(dco_stable)
  );

  // divide the chosen source by R
  fcg_out_divider #(
    .DW(8)
  ) u_div (
    .mclk(mclk),
    .resetn(resetn),
    .src_tick(src_tick),
    .divisor(div_val),
    .out_tick(clkgen_output)
  );

  // control registers; bit 0 of the first is never stored
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      ctl1_q <= fcg_pkg::CTL1_RESET;
      ctl2_q <= fcg_pkg::CTL2_RESET;
      trim_q <= fcg_pkg::TRIM_RESET;
    end
    else if (reg_wr)
    begin
      if (reg_addr == fcg_pkg::CTL1_ADDR)
        ctl1_q <= reg_wdata & fcg_pkg::CTL1_WMASK;
      if (reg_addr == fcg_pkg::CTL2_ADDR)
        ctl2_q <= reg_wdata;
      if (reg_addr == fcg_pkg::TRIM_ADDR)
        trim_q <= reg_wdata;
    end
  end

  // user writes land only in self-clocked mode; the loop steps it in engaged modes and it holds in bypassed external
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      filter_q <= fcg_pkg::FILTER_RESET;
    else if (reg_wr && mode_q == fcg_pkg::MODE_SELF && reg_addr == fcg_pkg::FILT_HI_ADDR)
      filter_q[11:8] <= reg_wdata[3:0];
    else if (reg_wr && mode_q == fcg_pkg::MODE_SELF && reg_addr == fcg_pkg::FILT_LO_ADDR)
      filter_q[7:0] <= reg_wdata;
    else if (adj_up && filter_q != 12'hfff)
      filter_q <= filter_q + 12'h001;
    else if (adj_down && filter_q != 12'h000)
      filter_q <= filter_q - 12'h001;
  end

  // External reference watchdog; saturates so the timeout is seen once
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      wd_q <= 16'h0000;
      ext_valid_q <= 1'b0;
    end
    else if (ext_ref_tick)
    begin
      wd_q <= 16'h0000;
      ext_valid_q <= 1'b1;
    end
    else
    begin
      if (!wd_timeout)
        wd_q <= wd_q + 16'h0001;
      else
        ext_valid_q <= 1'b0;
    end
  end

  // an external target mode is reachable only with the external reference present; self-clocked and internal engaged always are
  always_comb
  begin
    unique case (req)
      fcg_pkg::MODE_SELF: ref_ok = 1'b1;
      fcg_pkg::MODE_ENG_INT: ref_ok = 1'b1;
      fcg_pkg::MODE_BYP_EXT: ref_ok = ext_valid_q;
      fcg_pkg::MODE_ENG_EXT: ref_ok = ext_valid_q;
    endcase
  end

  // settle delay restarts on every write to the request field
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      settle_q <= 4'h0;
    else if (ctl1_wr || req == mode_q)
      settle_q <= 4'h0;
    else if (settle_q != SETTLE_LAST)
      settle_q <= settle_q + 4'h1;
  end

  // actual mode; a late reference simply keeps the old mode
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      mode_q <= fcg_pkg::MODE_SELF;
    else if (req != mode_q && settle_q == SETTLE_LAST && ref_ok)
      mode_q <= req;
  end

  // sticky flags; a new event wins over a clearing write
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      locked_prev_q <= 1'b0;
      lock_lost_q <= 1'b0;
      clk_lost_q <= 1'b0;
      irq_q <= 1'b0;
      lock_rst_q <= 1'b0;
      clk_rst_q <= 1'b0;
    end
    else
    begin
      locked_prev_q <= loop_locked;
      lock_lost_q <= lock_evt || (lock_lost_q && !stat_wr);
      clk_lost_q <= clk_evt || (clk_lost_q && !stat_wr);
      irq_q <= (lock_evt && !lock_loss_reset_enable) || (clk_evt && !clock_loss_reset_enable) || (irq_q && !stat_wr);
      lock_rst_q <= lock_evt && lock_loss_reset_enable;
      clk_rst_q <= clk_evt && clock_loss_reset_enable;
    end
  end

  // irg and DCO enables follow the actual mode; the oscillator enable also follows the request
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      irg_en_q <= 1'b0;
      dco_en_q <= 1'b1;
      osc_en_q <= 1'b0;
      hgo_en_q <= 1'b0;
    end
    else
    begin
      irg_en_q <= (mode_q == fcg_pkg::MODE_ENG_INT);
      dco_en_q <= (mode_q != fcg_pkg::MODE_BYP_EXT);
      osc_en_q <= (ctl1_q[fcg_pkg::REF_SELECT_BIT] && (ext_loop || req[1]))
                  || ctl1_q[fcg_pkg::OSC_KEEP_BIT];
      hgo_en_q <= ctl1_q[fcg_pkg::HIGH_GAIN_BIT] && ctl1_q[fcg_pkg::REF_SELECT_BIT];
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    rdata_d = 8'h00;
    unique case (reg_addr)
      fcg_pkg::CTL1_ADDR: rdata_d = ctl1_q;
      fcg_pkg::CTL2_ADDR: rdata_d = ctl2_q;
      fcg_pkg::STAT1_ADDR:
      begin
        rdata_d[fcg_pkg::MODE_ACT_LSB +: 2] = mode_q;
        rdata_d[fcg_pkg::EXT_VALID_BIT] = ext_valid_q;
        rdata_d[fcg_pkg::CLK_LOST_BIT] = clk_lost_q;
        rdata_d[fcg_pkg::LOCKED_BIT] = locked_prev_q;
        rdata_d[fcg_pkg::LOCK_LOST_BIT] = lock_lost_q;
        rdata_d[fcg_pkg::IRQ_BIT] = irq_q;
      end
      fcg_pkg::STAT2_ADDR: rdata_d[fcg_pkg::DCO_STABLE_BIT] = dco_stable;
      fcg_pkg::FILT_HI_ADDR: rdata_d = {4'h0, filter_q[11:8]};
      fcg_pkg::FILT_LO_ADDR: rdata_d = filter_q[7:0];
      fcg_pkg::TRIM_ADDR: rdata_d = trim_q;
      default: rdata_d = 8'h00;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      rdata_q <= 8'h00;
    else
      rdata_q <= reg_rd ? rdata_d : 8'h00;
  end

  assign reg_rdata = rdata_q;
  assign loop_filter_value = filter_q;
  assign osc_trim = trim_q;
  assign irg_enable = irg_en_q;
  assign dco_enable = dco_en_q;
  assign osc_enable = osc_en_q;
  assign high_gain_enable = hgo_en_q;
  assign clock_mode_actual = mode_q;
  assign irq_request = irq_q;
  assign lock_loss_reset = lock_rst_q;
  assign clock_loss_reset = clk_rst_q;

  // Checks on the block's own behaviour
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence s_lock_drop;
    engaged && locked_prev_q && !loop_locked;
  endsequence

  property p_mult_int;
    !ext_loop |-> loop_tgt == 12'(ctl2_q[6:4]) * 12'h080 + 12'h100;
  endproperty
  a_mult_int: assert property (p_mult_int) else $error("internal loop target wrong");

  property p_div;
    (div_val >> ctl2_q[2:0]) == 8'h01 && $countones(div_val) == 1;
  endproperty
  a_div: assert property (p_div) else $error("divisor decode wrong");

  property p_ext_pre;
    ext_loop && ctl1_q[fcg_pkg::RANGE_BIT] |-> loop_tgt == 12'(mult_n);
  endproperty
  a_ext_pre: assert property (p_ext_pre) else $error("prescale of one not applied");

  property p_reset_mode;
    !$past(resetn) |-> mode_q == fcg_pkg::MODE_SELF && filter_q == fcg_pkg::FILTER_RESET;
  endproperty
  a_reset_mode: assert property (p_reset_mode) else $error("not self-clocked after reset");

  property p_bit0;
    reg_rd && reg_addr == fcg_pkg::CTL1_ADDR |=> reg_rdata[0] == 1'b0;
  endproperty
  a_bit0: assert property (p_bit0) else $error("control bit 0 read as one");

  property p_settle;
    ctl1_wr |=> ##1 $stable(mode_q) [*3];
  endproperty
  a_settle: assert property (p_settle) else $error("mode changed too soon");

  property p_hold;
    req != mode_q && !ref_ok |=> $stable(mode_q);
  endproperty
  a_hold: assert property (p_hold) else $error("mode switched without reference");

  property p_lock_irq;
    s_lock_drop and !lock_loss_reset_enable |=> irq_q && !lock_rst_q;
  endproperty
  a_lock_irq: assert property (p_lock_irq) else $error("lock loss did not interrupt");

  property p_loss_clock_detect_disable;
    ctl1_q[fcg_pkg::LOC_DISABLE_BIT] |=> !clk_lost_q || $past(clk_lost_q);
  endproperty
  a_loss_clock_detect_disable: assert property (p_loss_clock_detect_disable) else $error("clock loss seen while disabled");

  property p_clear;
    stat_wr && !lock_evt && !clk_evt |=> !irq_q;
  endproperty
  a_clear: assert property (p_clear) else $error("status write left flag set");

  property p_filter;
    mode_q != fcg_pkg::MODE_SELF && !adj_up && !adj_down |=> $stable(filter_q);
  endproperty
  a_filter: assert property (p_filter) else $error("filter moved in engaged mode");

  property p_bypass_off;
    $past(mode_q) == fcg_pkg::MODE_BYP_EXT |-> !irg_en_q && !dco_en_q;
  endproperty
  a_bypass_off: assert property (p_bypass_off) else $error("bypass left oscillators on");
endmodule

// ---- fcg_ref_source.sv ----
// Tick source standing in for the oscillator, crystal or DCO side
`timescale 1ns/10ps
module fcg_ref_source (
  input wire logic mclk,
  input wire logic run,
  input wire logic [7:0] period,
  output logic tick
);
  logic [7:0] cnt_q;

  // One pulse per period; a stopped source stands still with its tick low
  always_ff @(posedge mclk)
  begin
    if (!run)
    begin
      cnt_q <= 8'h00;
      tick <= 1'b0;
    end
    else
    begin
      cnt_q <= (cnt_q + 8'h01 >= period) ? 8'h00 : cnt_q + 8'h01;
      tick <= (cnt_q + 8'h01 >= period);
    end
  end
endmodule

// ---- fcg_clock_config_tb.sv ----
// Self-checking bench for the clock generator configuration block
`timescale 1ns/10ps
module fcg_clock_config_tb;
  localparam int LOSS_CYC = 20;
  localparam int EXT_PER = 5;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic ext_run = 1'b0;
  logic [7:0] reg_rdata, osc_trim;
  logic [11:0] loop_filter_value;
  logic [1:0] clock_mode_actual;
  logic irg_tick, ext_ref_tick, dco_tick, clkgen_output, irg_enable, dco_enable;
  logic osc_enable, high_gain_enable, irq_request, lock_loss_reset, clock_loss_reset;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;

  always #4 mclk = ~mclk;

  // Far side: internal reference, DCO and a stoppable external reference
  // Internal reference and DCO held in reset with the block so their counters start from a known zero
  fcg_ref_source irg_src (.mclk(mclk), .run(resetn), .period(8'h03), .tick(irg_tick));
  fcg_ref_source dco_src (.mclk(mclk), .run(resetn), .period(8'h01), .tick(dco_tick));
  fcg_ref_source ext_src (.mclk(mclk), .run(ext_run), .period(8'(EXT_PER)),
    .tick(ext_ref_tick));

  fcg_clock_config #(.LOSS_TIMEOUT_CYC(LOSS_CYC)) fcg_clock_config_inst (
    .mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irg_tick(irg_tick),
    .ext_ref_tick(ext_ref_tick), .dco_tick(dco_tick), .clkgen_output(clkgen_output),
    .loop_filter_value(loop_filter_value), .osc_trim(osc_trim),
    .irg_enable(irg_enable), .dco_enable(dco_enable), .osc_enable(osc_enable),
    .high_gain_enable(high_gain_enable), .clock_mode_actual(clock_mode_actual),
    .irq_request(irq_request), .lock_loss_reset(lock_loss_reset),
    .clock_loss_reset(clock_loss_reset));

  // Divisor expected for a reduce code
  function automatic int r_of(input int code);
    return 1 << code;
  endfunction

  // Pulse counts may be off by one depending on divider phase
  function automatic logic near(input int seen, input int exp);
    return (seen >= exp - 1) && (seen <= exp + 1);
  endfunction

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the read edge
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic rdchk(input logic [2:0] a, input logic [7:0] e, input string what);
    logic [7:0] r;
    rd(a, r);
    chk(what, 12'(r), 12'(e));
  endtask

  task automatic wait_mode(input logic [1:0] m, output int n);
    n = 0;
    do
    begin
      @(posedge mclk);
      #1;
      n++;
    end while (clock_mode_actual !== m && n < 100);
  endtask

  task automatic count_out(output int c);
    c = 0;
    repeat (256)
    begin
      @(posedge mclk);
      #1;
      if (clkgen_output === 1'b1)
        c++;
    end
  endtask

  // Hang guard: a few thousand cycles are expected
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      num_errors++;
      stop_test;
    end
  end

  initial
  begin
    logic [7:0] d;
    logic [7:0] r;
    int n;
    void'($urandom(32'hd69885db));
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    #1;
    chk("mode_reset", 12'(clock_mode_actual), 12'h000);
    chk("dco_en_reset", 12'(dco_enable), 12'h001);
    rdchk(fcg_pkg::CTL1_ADDR, 8'h00, "ctl1_reset");
    rdchk(fcg_pkg::CTL2_ADDR, 8'h00, "ctl2_reset");
    rdchk(fcg_pkg::FILT_HI_ADDR, 8'h08, "filt_hi_reset");
    rdchk(fcg_pkg::TRIM_ADDR, 8'h80, "trim_reset");
    // Control one: bit 0 never stored; mode bits kept at self-clocked
    for (int i = 0; i < 5; i++)
    begin
      d = (i == 0) ? 8'ha5 : 8'($urandom()) & 8'he7;
      wr(fcg_pkg::CTL1_ADDR, d);
      rdchk(fcg_pkg::CTL1_ADDR, d & 8'hfe, "ctl1");
      chk("high_gain", 12'(high_gain_enable), 12'(d[7] & d[5]));
      chk("osc_en", 12'(osc_enable), 12'(d[2]));
    end
    // Every reduce code against DCO ticks arriving each cycle
    for (int c = 0; c < 8; c++)
    begin
      d = (8'($urandom()) & 8'hf8) | 8'(c);
      wr(fcg_pkg::CTL2_ADDR, d);
      rdchk(fcg_pkg::CTL2_ADDR, d, "ctl2");
      count_out(n);
      chk("scm_div", 12'(near(n, 256 / r_of(c))), 12'h001);
    end
    wr(fcg_pkg::FILT_HI_ADDR, 8'hf5);
    wr(fcg_pkg::FILT_LO_ADDR, 8'h3c);
    rdchk(fcg_pkg::FILT_HI_ADDR, 8'h05, "filt_hi");
    chk("filter", loop_filter_value, 12'h53c);
    d = 8'($urandom());
    wr(fcg_pkg::TRIM_ADDR, d);
    rdchk(fcg_pkg::TRIM_ADDR, d, "trim");
    chk("trim_out", 12'(osc_trim), 12'(d));
    wr(3'h7, 8'hff);
    rdchk(3'h7, 8'h00, "unmapped");
    wr(fcg_pkg::STAT2_ADDR, 8'hff);
    rd(fcg_pkg::STAT2_ADDR, r);
    chk("stat2_ro", 12'(r & 8'hfe), 12'h000);
    // Bypassed external: DCO off, filter frozen, output from the reference
    @(posedge mclk);
    ext_run <= 1'b1;
    repeat (10) @(posedge mclk);
    wr(fcg_pkg::CTL1_ADDR, 8'h10);
    wait_mode(2'b10, n);
    chk("fbe_settle", 12'(n), 12'h004);
    repeat (2) @(posedge mclk);
    #1;
    chk("fbe_dco", 12'(dco_enable), 12'h000);
    chk("fbe_irg", 12'(irg_enable), 12'h000);
    wr(fcg_pkg::FILT_LO_ADDR, 8'h11);
    rdchk(fcg_pkg::FILT_LO_ADDR, 8'h3c, "filt_frozen");
    wr(fcg_pkg::CTL2_ADDR, 8'h01);
    count_out(n);
    chk("fbe_div", 12'(near(n, 256 / EXT_PER / r_of(1))), 12'h001);
    // Lost reference raises the interrupt, a status write clears it
    wr(fcg_pkg::CTL2_ADDR, 8'h00);
    ext_run <= 1'b0;
    n = 0;
    while (irq_request !== 1'b1 && n < 2 * LOSS_CYC)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk("loss_irq", 12'(irq_request), 12'h001);
    rd(fcg_pkg::STAT1_ADDR, r);
    chk("loss_flag", 12'(r[fcg_pkg::CLK_LOST_BIT]), 12'h001);
    @(posedge mclk);
    ext_run <= 1'b1;
    repeat (2 * EXT_PER) @(posedge mclk);
    wr(fcg_pkg::STAT1_ADDR, 8'hff);
    @(posedge mclk);
    #1;
    chk("irq_clear", 12'(irq_request), 12'h000);
    // With its reset enable set, loss gives a reset pulse and no interrupt
    wr(fcg_pkg::CTL2_ADDR, 8'h08);
    ext_run <= 1'b0;
    n = 0;
    while (clock_loss_reset !== 1'b1 && n < 2 * LOSS_CYC)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk("loss_reset", 12'(clock_loss_reset), 12'h001);
    chk("loss_no_irq", 12'(irq_request), 12'h000);
    // Engaged external waits for a live reference
    wr(fcg_pkg::CTL1_ADDR, 8'h18);
    repeat (30) @(posedge mclk);
    #1;
    chk("fee_held", 12'(clock_mode_actual), 12'h002);
    @(posedge mclk);
    ext_run <= 1'b1;
    wait_mode(2'b11, n);
    chk("fee_mode", 12'(clock_mode_actual), 12'h003);
    repeat (2) @(posedge mclk);
    #1;
    chk("fee_irg", 12'(irg_enable), 12'h000);
    chk("fee_dco", 12'(dco_enable), 12'h001);
    // Range one makes the target N itself, so the loop locks on the 5-cycle reference
    // smallest N, R
    wr(fcg_pkg::CTL2_ADDR, 8'h00);
    wr(fcg_pkg::CTL1_ADDR, 8'h78);
    repeat (6 * EXT_PER) @(posedge mclk);
    rd(fcg_pkg::STAT1_ADDR, r);
    chk("fee_locked", 12'(r[fcg_pkg::LOCKED_BIT]), 12'h001);
    chk("fee_osc", 12'(osc_enable), 12'h001);
    rdchk(fcg_pkg::STAT2_ADDR, 8'h01, "dco_stable");
    // lock loss reset: N of 18 cannot be met, reset enable set
    wr(fcg_pkg::CTL2_ADDR, 8'hf0);
    n = 0;
    while (lock_loss_reset !== 1'b1 && n < 4 * EXT_PER)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk("lock_rst", 12'(lock_loss_reset), 12'h001);
    chk("lock_no_irq", 12'(irq_request), 12'h000);
    // Engaged internal needs no reference check
    wr(fcg_pkg::CTL1_ADDR, 8'h08);
    wait_mode(2'b01, n);
    chk("fei_settle", 12'(n), 12'h004);
    repeat (2) @(posedge mclk);
    #1;
    chk("fei_irg", 12'(irg_enable), 12'h001);
    chk("fei_dco", 12'(dco_enable), 12'h001);
    stop_test;
  end
endmodule
